// File: inc/atrim_pkg.sv
// Constants shared by the alarm and timing trim register logic.
package atrim_pkg;

    // ------------------------------------------------------------------
    // Serial frame layout
    // ------------------------------------------------------------------
    localparam int          FRAME_BITS = 24;
    localparam int          ADDR_BITS  = 15;
    localparam int          DATA_BITS  = 8;
    localparam logic [4:0]  CMD_LAST   = 5'h0f;
    localparam logic [4:0]  FRAME_LAST = 5'h17;
    localparam int          RW_POS     = 23;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam logic [14:0] OFF_ALARM_SUMMARY = 15'h02c0;
    localparam logic [14:0] OFF_ALARM_FLAGS   = 15'h02c1;
    localparam logic [14:0] OFF_ALARM_MASK    = 15'h02c2;

    localparam int TRIM_NUM       = 5;
    localparam int TRIM_DUAL_A    = 0;
    localparam int TRIM_DUAL_B    = 1;
    localparam int TRIM_IL_A_IN1  = 2;
    localparam int TRIM_IL_B_IN1  = 3;
    localparam int TRIM_IL_A_IN2  = 4;

    localparam logic [TRIM_NUM-1:0][14:0] TRIM_OFFSETS = {
        15'h031a, 15'h0315, 15'h0314, 15'h0313, 15'h0310
    };

    // ------------------------------------------------------------------
    // Alarm field layout and reset values
    // ------------------------------------------------------------------
    localparam int         MISMATCH_BIT  = 0;
    localparam int         REALIGN_BIT   = 2;
    localparam logic [7:0] ALARM_IMPL    = 8'h05;
    localparam logic [7:0] ALARM_FLAGS_RST = 8'h05;
    localparam logic [7:0] ALARM_MASK_RST  = 8'h05;
    localparam logic [7:0] TRIM_RST      = 8'h00;

    typedef enum logic [1:0] {
        SPI_IDLE,
        SPI_CMD,
        SPI_DATA,
        SPI_DONE
    } atrim_spi_e;

endpackage : atrim_pkg

// File: hdl/atrim_trim_bank.sv
// Timing trim register bank loaded from fuse values.
`timescale 1ns/1ps

module atrim_trim_bank
    import atrim_pkg::*;
(
    // Clock and reset
    input  wire logic                              clk_i,
    input  wire logic                              rst_n_i,
    // Fuse load request and values
    input  wire logic                              reload_i,
    input  wire logic                              fuse_valid_i,
    input  wire logic [TRIM_NUM-1:0][DATA_BITS-1:0] fuse_trim_i,
    // Register writes
    input  wire logic [TRIM_NUM-1:0]               wr_en_i,
    input  wire logic [DATA_BITS-1:0]              wr_data_i,
    // Stored values
    output logic                                   loading_o,
    output logic      [TRIM_NUM-1:0][DATA_BITS-1:0] trim_o
);

    logic pending_reg;
    logic load_now;

    // Fuse values cannot be taken under the asynchronous reset, so a pending
    // flag holds off the copy until the clock runs after release.
    assign load_now  = pending_reg & fuse_valid_i;
    assign loading_o = pending_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pending_reg <= 1'b1;
        end else if (reload_i) begin
            pending_reg <= 1'b1;
        end else if (load_now) begin
            pending_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // One read/write trim byte per core and mode
    // ------------------------------------------------------------------
    for (genvar i = 0; i < TRIM_NUM; i++) begin : g_trim
        logic [DATA_BITS-1:0] value_reg;
        always_ff @(posedge clk_i or negedge rst_n_i) begin
            if (!rst_n_i) begin
                value_reg <= TRIM_RST;
            end else if (load_now) begin
                value_reg <= fuse_trim_i[i];
            end else if (wr_en_i[i] && !pending_reg) begin
                value_reg <= wr_data_i;
            end
        end
        assign trim_o[i] = value_reg;
    end

endmodule : atrim_trim_bank

// File: hdl/atrim_regs.sv
// Alarm flag, alarm mask and timing trim registers behind the serial port.
//
// Overview of operation
// - The alarm flag register holds 0x05 after reset so both flags read set.
// - A SYSREF phase realignment event sets the flag in bit 2.
// - A channel A/B clock divider mismatch sets the flag in bit 0.
// - Writing one to a flag bit clears it and writing zero leaves it alone.
// - Power-on reset and soft reset both force every alarm flag to one.
// - The alarm mask register resets to 0x05 so both sources start suppressed.
// - With mask bit 2 set the realign flag does not reach the summary but still records.
// - With mask bit 0 set the mismatch flag does not reach the summary.
// - Bits 7 to 3 and bit 1 of the flag and mask registers are reserved zero.
// - Each trim register is an 8-bit read/write value setting one core's sampling instant.
// - Every trim register takes its value after reset from the fuse values.
// - Trim values stay readable and can be overwritten by software.
// - In dual mode core A uses the trim at 0x310 and core B the one at 0x313.
// - Interleaved mode uses 0x314 for core A input one, 0x315 for core B, 0x31A for core A input two.
// - The read-only summary bit at 0x2C0 bit 0 is one when any unmasked flag is set.
// - A status pin select routes the summary bit onto the calibration status pin.
`timescale 1ns/1ps

module atrim_regs
    import atrim_pkg::*;
(
    // Clock and reset
    input  wire logic                               clk_i,
    input  wire logic                               rst_n_i,
    input  wire logic                               soft_reset_i,
    // Serial configuration pins
    input  wire logic                               spi_sclk_i,
    input  wire logic                               spi_cs_n_i,
    input  wire logic                               spi_sdi_i,
    output logic                                    spi_sdo_o,
    output logic                                    spi_sdo_oe_o,
    // Alarm events
    input  wire logic                               realign_event_i,
    input  wire logic                               divider_mismatch_i,
    // Fuse values
    input  wire logic                               fuse_valid_i,
    input  wire logic [TRIM_NUM-1:0][DATA_BITS-1:0] fuse_trim_i,
    // Operating mode
    input  wire logic                               interleave_i,
    input  wire logic                               sample_in2_i,
    // Status pin
    input  wire logic                               status_pin_sel_i,
    input  wire logic                               cal_status_i,
    output logic                                    cal_status_o,
    output logic                                    alarm_summary_o,
    // Trim outputs
    output logic                                    trim_loading_o,
    output logic      [DATA_BITS-1:0]               core_a_trim_o,
    output logic      [DATA_BITS-1:0]               core_b_trim_o
);

    function automatic logic addr_is(input logic [14:0] a, input logic [14:0] off);
        addr_is = (a == off);
    endfunction : addr_is

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    logic [2:0] sclk_sync_reg;
    logic [1:0] csn_sync_reg;
    logic [1:0] sdi_sync_reg;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            sclk_sync_reg <= 3'h0;
            csn_sync_reg  <= 2'h3;
            sdi_sync_reg  <= 2'h0;
        end else begin
            sclk_sync_reg <= {sclk_sync_reg[1:0], spi_sclk_i};
            csn_sync_reg  <= {csn_sync_reg[0], spi_cs_n_i};
            sdi_sync_reg  <= {sdi_sync_reg[0], spi_sdi_i};
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic cs_n_s;
    logic sdi_s;

    assign sclk_rise = sclk_sync_reg[1] & ~sclk_sync_reg[2];
    assign sclk_fall = ~sclk_sync_reg[1] & sclk_sync_reg[2];
    assign cs_n_s    = csn_sync_reg[1];
    assign sdi_s     = sdi_sync_reg[1];

    // ------------------------------------------------------------------
    // Serial frame engine
    // ------------------------------------------------------------------
    atrim_spi_e                spi_state_reg;
    logic [4:0]                bit_cnt_reg;
    logic [FRAME_BITS-2:0]     shift_in_reg;
    logic [DATA_BITS-1:0]      rd_shift_reg;
    logic                      is_read_reg;
    logic                      wr_stb_reg;
    logic [ADDR_BITS-1:0]      wr_addr_reg;
    logic [DATA_BITS-1:0]      wr_data_reg;
    logic [DATA_BITS-1:0]      rd_data;
    logic [ADDR_BITS-1:0]      cmd_addr;

    assign cmd_addr = shift_in_reg[ADDR_BITS-2:0] == 14'h0 ? {shift_in_reg[ADDR_BITS-2:0], sdi_s}
                                                          : {shift_in_reg[ADDR_BITS-2:0], sdi_s};

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            spi_state_reg <= SPI_IDLE;
            bit_cnt_reg   <= 5'h00;
            shift_in_reg  <= '0;
            rd_shift_reg  <= 8'h00;
            is_read_reg   <= 1'b0;
            wr_stb_reg    <= 1'b0;
            wr_addr_reg   <= 15'h0000;
            wr_data_reg   <= 8'h00;
        end else begin
            wr_stb_reg <= 1'b0;
            if (cs_n_s) begin
                spi_state_reg <= SPI_IDLE;
                bit_cnt_reg   <= 5'h00;
            end else begin
                case (spi_state_reg)
                    SPI_IDLE: begin
                        spi_state_reg <= SPI_CMD;
                        bit_cnt_reg   <= 5'h00;
                    end
                    SPI_CMD: begin
                        if (sclk_rise) begin
                            shift_in_reg <= {shift_in_reg[FRAME_BITS-3:0], sdi_s};
                            bit_cnt_reg  <= bit_cnt_reg + 5'h01;
                            if (bit_cnt_reg == CMD_LAST) begin
                                is_read_reg   <= shift_in_reg[ADDR_BITS-1];
                                wr_addr_reg   <= cmd_addr;
                                rd_shift_reg  <= rd_data;
                                spi_state_reg <= SPI_DATA;
                            end
                        end
                    end
                    SPI_DATA: begin
                        if (sclk_fall) begin
                            rd_shift_reg <= {rd_shift_reg[DATA_BITS-2:0], 1'b0};
                        end
                        if (sclk_rise) begin
                            shift_in_reg <= {shift_in_reg[FRAME_BITS-3:0], sdi_s};
                            bit_cnt_reg  <= bit_cnt_reg + 5'h01;
                            if (bit_cnt_reg == FRAME_LAST) begin
                                wr_data_reg   <= {shift_in_reg[DATA_BITS-2:0], sdi_s};
                                wr_stb_reg    <= ~is_read_reg;
                                spi_state_reg <= SPI_DONE;
                            end
                        end
                    end
                    SPI_DONE: begin
                        spi_state_reg <= SPI_DONE;
                    end
                    default: begin
                        spi_state_reg <= SPI_IDLE;
                    end
                endcase
            end
        end
    end

    assign spi_sdo_o    = rd_shift_reg[DATA_BITS-1];
    assign spi_sdo_oe_o = is_read_reg & (spi_state_reg == SPI_DATA) & ~cs_n_s;

    // ------------------------------------------------------------------
    // Alarm flags and mask
    // ------------------------------------------------------------------
    logic [7:0] flags_reg;
    logic [7:0] flags_next;
    logic [7:0] mask_reg;
    logic [7:0] events;
    logic [7:0] w1c_bits;
    logic       wr_flags;
    logic       wr_mask;

    assign wr_flags = wr_stb_reg & addr_is(wr_addr_reg, OFF_ALARM_FLAGS);
    assign wr_mask  = wr_stb_reg & addr_is(wr_addr_reg, OFF_ALARM_MASK);
    assign events   = {5'h00, realign_event_i, 1'b0, divider_mismatch_i};
    assign w1c_bits = wr_flags ? wr_data_reg : 8'h00;
    // The set term is ORed last so a same-cycle event survives the clear.
    assign flags_next = ((flags_reg & ~w1c_bits) | events) & ALARM_IMPL;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flags_reg <= ALARM_FLAGS_RST;
            mask_reg  <= ALARM_MASK_RST;
        end else if (soft_reset_i) begin
            flags_reg <= ALARM_FLAGS_RST;
            mask_reg  <= ALARM_MASK_RST;
        end else begin
            flags_reg <= flags_next;
            if (wr_mask) begin
                mask_reg <= wr_data_reg & ALARM_IMPL;
            end
        end
    end

    assign alarm_summary_o = |(flags_reg & ~mask_reg & ALARM_IMPL);
    assign cal_status_o    = status_pin_sel_i ? alarm_summary_o : cal_status_i;

    // ------------------------------------------------------------------
    // Trim bank and mode selection
    // ------------------------------------------------------------------
    logic [TRIM_NUM-1:0]                 trim_wr_en;
    logic [TRIM_NUM-1:0][DATA_BITS-1:0]  trim_vals;
    logic [DATA_BITS-1:0]                trim_rd;

    for (genvar i = 0; i < TRIM_NUM; i++) begin : g_trim_dec
        assign trim_wr_en[i] = wr_stb_reg & addr_is(wr_addr_reg, TRIM_OFFSETS[i]);
    end

    always_comb begin
        trim_rd = 8'h00;
        for (int i = 0; i < TRIM_NUM; i++) begin
            if (addr_is(cmd_addr, TRIM_OFFSETS[i])) begin
                trim_rd = trim_vals[i];
            end
        end
    end

    atrim_trim_bank u_trim_bank (
        .clk_i        (clk_i),
        .rst_n_i      (rst_n_i),
        .reload_i     (soft_reset_i),
        .fuse_valid_i (fuse_valid_i),
        .fuse_trim_i  (fuse_trim_i),
        .wr_en_i      (trim_wr_en),
        .wr_data_i    (wr_data_reg),
        .loading_o    (trim_loading_o),
        .trim_o       (trim_vals)
    );

    // Core B in interleaved mode has only the input-one trim in this bank.
    assign core_a_trim_o = !interleave_i ? trim_vals[TRIM_DUAL_A] :
                           sample_in2_i  ? trim_vals[TRIM_IL_A_IN2] :
                                           trim_vals[TRIM_IL_A_IN1];
    assign core_b_trim_o = interleave_i ? trim_vals[TRIM_IL_B_IN1] :
                                          trim_vals[TRIM_DUAL_B];

    // ------------------------------------------------------------------
    // Read data selection
    // ------------------------------------------------------------------
    assign rd_data = addr_is(cmd_addr, OFF_ALARM_SUMMARY) ? {7'h00, alarm_summary_o} :
                     addr_is(cmd_addr, OFF_ALARM_FLAGS)   ? flags_reg :
                     addr_is(cmd_addr, OFF_ALARM_MASK)    ? mask_reg :
                                                            trim_rd;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    property p_flags_reset;
        @(posedge clk_i) disable iff (!rst_n_i)
        soft_reset_i |=> (flags_reg == 8'h05);
    endproperty
    a_flags_reset: assert property (p_flags_reset) else $error("flags not 0x05 after soft reset");

    property p_mask_reset;
        @(posedge clk_i) disable iff (!rst_n_i)
        soft_reset_i |=> (mask_reg == 8'h05) && alarm_summary_o == 1'b0;
    endproperty
    a_mask_reset: assert property (p_mask_reset) else $error("mask not 0x05 after soft reset");

    property p_realign_set;
        @(posedge clk_i) disable iff (!rst_n_i)
        realign_event_i |=> flags_reg[2];
    endproperty
    a_realign_set: assert property (p_realign_set) else $error("realign event lost");

    property p_mismatch_set;
        @(posedge clk_i) disable iff (!rst_n_i)
        divider_mismatch_i |=> flags_reg[0];
    endproperty
    a_mismatch_set: assert property (p_mismatch_set) else $error("mismatch event lost");

    property p_w1c_clear;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr_flags && wr_data_reg[2] && !realign_event_i && !soft_reset_i) |=> !flags_reg[2];
    endproperty
    a_w1c_clear: assert property (p_w1c_clear) else $error("write one did not clear");

    property p_w0_keep;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr_flags && !wr_data_reg[0] && flags_reg[0]) |=> flags_reg[0];
    endproperty
    a_w0_keep: assert property (p_w0_keep) else $error("write zero cleared flag");

    property p_clear_race;
        @(posedge clk_i) disable iff (!rst_n_i)
        (wr_flags && wr_data_reg[0] && divider_mismatch_i) |=> flags_reg[0];
    endproperty
    a_clear_race: assert property (p_clear_race) else $error("event lost to clear");

    property p_summary;
        @(posedge clk_i) disable iff (!rst_n_i)
        alarm_summary_o == ((flags_reg[2] && !mask_reg[2]) || (flags_reg[0] && !mask_reg[0]));
    endproperty
    a_summary: assert property (p_summary) else $error("summary bit wrong");

    property p_reserved;
        @(posedge clk_i) disable iff (!rst_n_i)
        ((flags_reg | mask_reg) & 8'hfa) == 8'h00;
    endproperty
    a_reserved: assert property (p_reserved) else $error("reserved bit set");

    property p_pin_route;
        @(posedge clk_i) disable iff (!rst_n_i)
        status_pin_sel_i |-> (cal_status_o == alarm_summary_o);
    endproperty
    a_pin_route: assert property (p_pin_route) else $error("summary not on status pin");

    property p_trim_write;
        @(posedge clk_i) disable iff (!rst_n_i)
        (trim_wr_en[TRIM_DUAL_A] && !trim_loading_o && !interleave_i && !soft_reset_i)
            ##1 !interleave_i |-> core_a_trim_o == $past(wr_data_reg);
    endproperty
    a_trim_write: assert property (p_trim_write) else $error("trim write not applied");

    c_realign: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_flags ##1 realign_event_i ##1 flags_reg[2]);
    c_read: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        spi_sdo_oe_o ##1 spi_state_reg == SPI_DONE);
    c_summary: cover property (@(posedge clk_i) disable iff (!rst_n_i)
        wr_mask ##1 alarm_summary_o);

endmodule : atrim_regs

// File: tb/tb.sv
// Self-checking testbench for the alarm and timing trim registers.
`timescale 1ns/1ps

module tb;
    import atrim_pkg::*;

    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic                               clk_i, rst_n_i, soft_reset_i;
    logic                               spi_sclk_i, spi_cs_n_i, spi_sdi_i;
    logic                               spi_sdo_o, spi_sdo_oe_o;
    logic                               realign_event_i, divider_mismatch_i;
    logic                               fuse_valid_i;
    logic [TRIM_NUM-1:0][DATA_BITS-1:0] fuse_trim_i;
    logic                               interleave_i, sample_in2_i;
    logic                               status_pin_sel_i, cal_status_i, cal_status_o;
    logic                               alarm_summary_o, trim_loading_o;
    logic [DATA_BITS-1:0]               core_a_trim_o, core_b_trim_o;
    int                                 n_errors, checks_done;
    logic [7:0]                         nv [TRIM_NUM];

    atrim_regs uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .soft_reset_i(soft_reset_i),
        .spi_sclk_i(spi_sclk_i), .spi_cs_n_i(spi_cs_n_i), .spi_sdi_i(spi_sdi_i),
        .spi_sdo_o(spi_sdo_o), .spi_sdo_oe_o(spi_sdo_oe_o),
        .realign_event_i(realign_event_i), .divider_mismatch_i(divider_mismatch_i),
        .fuse_valid_i(fuse_valid_i), .fuse_trim_i(fuse_trim_i),
        .interleave_i(interleave_i), .sample_in2_i(sample_in2_i),
        .status_pin_sel_i(status_pin_sel_i), .cal_status_i(cal_status_i),
        .cal_status_o(cal_status_o), .alarm_summary_o(alarm_summary_o),
        .trim_loading_o(trim_loading_o), .core_a_trim_o(core_a_trim_o),
        .core_b_trim_o(core_b_trim_o));

    initial begin
        clk_i = 1'b0;
        forever #2.5 clk_i = ~clk_i;
    end

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : finish_test

    // Sclk phases of six clocks keep well clear of the three-flop sampling.
    task automatic xfer(input logic rw, input logic [14:0] addr, input logic [7:0] wd,
                        output logic [7:0] rv, output logic oe);
        logic [23:0] f;
        f = {rw, addr, wd};
        rv = 8'h00;
        oe = 1'b0;
        spi_cs_n_i = 1'b0;
        repeat (4) @(negedge clk_i);
        for (int i = 23; i >= 0; i--) begin
            spi_sdi_i = f[i];
            spi_sclk_i = 1'b0;
            repeat (6) @(negedge clk_i);
            if (i == 4) oe = spi_sdo_oe_o;
            spi_sclk_i = 1'b1;
            repeat (6) @(negedge clk_i);
            // A read bit stands from one falling edge to the next, so it is
            // taken at the end of the high phase, before the fall shifts it.
            if (i >= 1 && i <= 8) rv[i-1] = spi_sdo_o;
        end
        spi_sclk_i = 1'b0;
        repeat (6) @(negedge clk_i);
        spi_cs_n_i = 1'b1;
        repeat (8) @(negedge clk_i);
    endtask : xfer

    task automatic wr(input logic [14:0] a, input logic [7:0] d);
        logic [7:0] r;
        logic       o;
        xfer(1'b0, a, d, r, o);
    endtask : wr

    task automatic rd(input logic [14:0] a, input logic [7:0] exp);
        logic [7:0] r;
        logic       o;
        xfer(1'b1, a, 8'h00, r, o);
        chk(r, exp);
        chk({7'h00, o}, 8'h01);
    endtask : rd

    task automatic pulse(input int which);
        if (which == 0) realign_event_i = 1'b1;
        else divider_mismatch_i = 1'b1;
        @(negedge clk_i);
        realign_event_i = 1'b0;
        divider_mismatch_i = 1'b0;
        @(negedge clk_i);
    endtask : pulse

    // ------------------------------------------------------------------
    // Watchdog
    // ------------------------------------------------------------------
    initial begin
        #400us;
        n_errors++;
        finish_test();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        n_errors = 0; checks_done = 0;
        rst_n_i = 1'b0; soft_reset_i = 1'b0; spi_sclk_i = 1'b0; spi_cs_n_i = 1'b1;
        spi_sdi_i = 1'b0; realign_event_i = 1'b0; divider_mismatch_i = 1'b0;
        fuse_valid_i = 1'b1; interleave_i = 1'b0; sample_in2_i = 1'b0;
        status_pin_sel_i = 1'b0; cal_status_i = 1'b0;
        fuse_trim_i = {8'h5a, 8'h4b, 8'h3c, 8'h2d, 8'h1e};
        repeat (8) @(negedge clk_i);
        rst_n_i = 1'b1;
        repeat (6) @(negedge clk_i);

        rd(OFF_ALARM_FLAGS, 8'h05);
        rd(OFF_ALARM_MASK, 8'h05);
        chk({7'h00, alarm_summary_o}, 8'h00);
        chk({7'h00, trim_loading_o}, 8'h00);
        for (int k = 0; k < TRIM_NUM; k++) rd(TRIM_OFFSETS[k], fuse_trim_i[k]);
        $display("test reset_values done");

        for (int k = 0; k < TRIM_NUM; k++) begin
            nv[k] = 8'h81 + 8'(k * 17);
            wr(TRIM_OFFSETS[k], nv[k]);
        end
        for (int k = 0; k < TRIM_NUM; k++) rd(TRIM_OFFSETS[k], nv[k]);
        chk(core_a_trim_o, nv[TRIM_DUAL_A]);
        chk(core_b_trim_o, nv[TRIM_DUAL_B]);
        interleave_i = 1'b1;
        @(negedge clk_i);
        chk(core_a_trim_o, nv[TRIM_IL_A_IN1]);
        chk(core_b_trim_o, nv[TRIM_IL_B_IN1]);
        sample_in2_i = 1'b1;
        @(negedge clk_i);
        chk(core_a_trim_o, nv[TRIM_IL_A_IN2]);
        $display("test trim_access done");

        wr(OFF_ALARM_FLAGS, 8'h00);
        rd(OFF_ALARM_FLAGS, 8'h05);
        wr(OFF_ALARM_FLAGS, 8'h01);
        rd(OFF_ALARM_FLAGS, 8'h04);
        wr(OFF_ALARM_FLAGS, 8'hff);
        rd(OFF_ALARM_FLAGS, 8'h00);
        wr(OFF_ALARM_MASK, 8'hff);
        rd(OFF_ALARM_MASK, 8'h05);
        wr(OFF_ALARM_MASK, 8'h00);
        rd(OFF_ALARM_MASK, 8'h00);
        chk({7'h00, alarm_summary_o}, 8'h00);
        $display("test clear_and_mask done");

        pulse(0);
        chk({7'h00, alarm_summary_o}, 8'h01);
        status_pin_sel_i = 1'b1;
        @(negedge clk_i);
        chk({7'h00, cal_status_o}, 8'h01);
        rd(OFF_ALARM_FLAGS, 8'h04);
        rd(OFF_ALARM_SUMMARY, 8'h01);
        wr(OFF_ALARM_MASK, 8'h04);
        chk({7'h00, alarm_summary_o}, 8'h00);
        wr(OFF_ALARM_FLAGS, 8'h04);
        pulse(0);
        rd(OFF_ALARM_FLAGS, 8'h04);
        pulse(1);
        rd(OFF_ALARM_FLAGS, 8'h05);
        chk({7'h00, alarm_summary_o}, 8'h01);
        wr(OFF_ALARM_MASK, 8'h05);
        chk({7'h00, alarm_summary_o}, 8'h00);
        status_pin_sel_i = 1'b0;
        cal_status_i = 1'b1;
        @(negedge clk_i);
        chk({7'h00, cal_status_o}, 8'h01);
        cal_status_i = 1'b0;
        @(negedge clk_i);
        chk({7'h00, cal_status_o}, 8'h00);
        $display("test alarm_events done");

        // Holding the event across the clearing write lands both in one cycle.
        wr(OFF_ALARM_FLAGS, 8'h04);
        divider_mismatch_i = 1'b1;
        wr(OFF_ALARM_FLAGS, 8'h01);
        divider_mismatch_i = 1'b0;
        rd(OFF_ALARM_FLAGS, 8'h01);
        wr(OFF_ALARM_SUMMARY, 8'hff);
        rd(OFF_ALARM_SUMMARY, 8'h00);
        rd(15'h0100, 8'h00);
        $display("test collision_unmapped done");

        wr(OFF_ALARM_FLAGS, 8'h05);
        wr(OFF_ALARM_MASK, 8'h00);
        soft_reset_i = 1'b1;
        @(negedge clk_i);
        soft_reset_i = 1'b0;
        repeat (4) @(negedge clk_i);
        rd(OFF_ALARM_FLAGS, 8'h05);
        rd(OFF_ALARM_MASK, 8'h05);
        rd(TRIM_OFFSETS[TRIM_DUAL_A], fuse_trim_i[TRIM_DUAL_A]);
        $display("test soft_reset done");

        finish_test();
    end

endmodule : tb
